// >>> urm_pkg.sv
/*
 * Shared constants and carrier types of the RS-485 capable serial port:
 * register offsets, field positions, reset values, timing counts.
 * Assumes a single 250 MHz clock and an APB master with 32-bit data.
 */
package urm_pkg;

    localparam int unsigned CLK_MHZ = 250;

    // register byte offsets
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_IEN = 8'h04;
    localparam logic [7:0] OFF_FIFO_CTL = 8'h08;
    localparam logic [7:0] OFF_LINE_CTL = 8'h0c;
    localparam logic [7:0] OFF_MODEM_CTL = 8'h10;
    localparam logic [7:0] OFF_MODEM_STS = 8'h14;
    localparam logic [7:0] OFF_FIFO_STS = 8'h18;
    localparam logic [7:0] OFF_INT_STS = 8'h1c;
    localparam logic [7:0] OFF_TIMEOUT = 8'h20;
    localparam logic [7:0] OFF_BAUD = 8'h24;
    localparam logic [7:0] OFF_IRDA = 8'h28;
    localparam logic [7:0] OFF_ALT_CTL = 8'h2c;
    localparam logic [7:0] OFF_FUNC_SEL = 8'h30;

    // reset values
    localparam logic [31:0] RST_FIFO_CTL = 32'h0000_0101;
    localparam logic [31:0] RST_MODEM_CTL = 32'h0000_0200;
    localparam logic [31:0] RST_MODEM_STS = 32'h0000_0001;
    localparam logic [31:0] RST_FIFO_STS = 32'h1040_4000;
    localparam logic [31:0] RST_INT_STS = 32'h0000_000a;
    localparam logic [31:0] RST_BAUD = 32'h0f00_0000;
    localparam logic [31:0] RST_IRDA = 32'h0000_0040;

    // field positions
    localparam int unsigned FCR_RX_OFF = 8;
    localparam int unsigned LCR_PAR_EN = 3;
    localparam int unsigned LCR_EVEN = 4;
    localparam int unsigned LCR_STICK = 5;
    localparam int unsigned LCR_BREAK = 6;
    localparam int unsigned LCR_TWO_STOP = 2;
    localparam int unsigned MCR_RTS = 1;
    localparam int unsigned MCR_LEV_RTS = 9;
    localparam int unsigned ALT_MULTIDROP = 8;
    localparam int unsigned ALT_AUTO_ADDR = 9;
    localparam int unsigned ALT_AUTO_DIR = 10;
    localparam int unsigned ALT_ADDR_LSB = 24;
    localparam int unsigned TOR_TURN_LSB = 8;
    localparam int unsigned ISR_ADDR_IF = 16;
    localparam logic [1:0] FUNC_RS485 = 2'h3;

    // turnaround delay unit is one bit time; bit time fixed for this block
    localparam int unsigned BIT_TIME_NS = 400;
    localparam int unsigned BIT_CYCLES = (BIT_TIME_NS * CLK_MHZ) / 1000;
    localparam logic [7:0] BIT_CNT_MAX = 8'(BIT_CYCLES - 1);

    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_SHIFT = 4'b0010,
        TX_HOLD = 4'b0100,
        TX_DELAY = 4'b1000
    } urm_tx_e;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b01,
        RX_SHIFT = 2'b10
    } urm_rx_e;

    typedef struct packed {
        logic [8:0] data;
        logic valid;
    } urm_char_s;

endpackage

// >>> urm_uart.sv
/*
 * RS-485 capable serial port with APB register access.
 * One clock, asynchronous active-low reset. Line pins come from outside
 * and are synchronised. Frames are fixed: start, 8 data, 9th bit, stop.
 */
// Behaviour
// - RS-485 behaviour only when function select picks the RS-485 function
// - RTS output serves as line driver enable in RS-485 operation
// - ninth bit one marks an address character, zero marks data
// - stick parity with even gives ninth bit 0, with odd gives 1
// - normal multidrop, auto address, auto direction are independent enables
// - driver enable released only after programmed delay past last stop bit
// - multidrop with receiver disabled drops characters until an address arrives
// - multidrop with receiver enabled stores every character
// - address character in multidrop raises an interrupt request
// - next address character clears receiver disable and gets stored
// - auto address drops characters until matching address arrives, stores it
// - after a match all characters stored until a differing address
// - auto direction drives RTS one to enable driver, zero to tristate
// - RTS active level invertible by the RTS level bit
// - offset zero reads the receive buffer, writes transmit holding
// - receiver disable sits at FIFO control bit 8, one disables
// - RTS level bit at modem control bit 9, one selects high level
`timescale 1ns/1ps
module urm_uart (
    input wire logic ref_clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic rxPin, // serial line input
    output logic txPin, // serial line output
    output logic rtsPin, // rts / driver enable
    output logic addrIrq // address character request
);

    typedef struct packed {
        logic [31:0] ien;
        logic [31:0] fifoCtl;
        logic [31:0] lineCtl;
        logic [31:0] modemCtl;
        logic [31:0] timeout;
        logic [31:0] baud;
        logic [31:0] irda;
        logic [31:0] altCtl;
        logic [31:0] funcSel;
        logic addrFlag;
        logic [7:0] rxBuf;
        logic rxFull;
        logic [31:0] rdata;
        logic [1:0] rxSync;
        urm_pkg::urm_tx_e txState;
        logic [7:0] txBitCnt;
        logic [3:0] txIdx;
        logic [9:0] txShift;
        logic [7:0] txTurn;
        logic txOut;
        logic [7:0] thr;
        logic thrFull;
        logic driveEn;
        urm_pkg::urm_rx_e rxState;
        logic [7:0] rxBitCnt;
        logic [3:0] rxIdx;
        logic [8:0] rxShift;
        logic addrMatched;
        logic rtsOut;
    } urm_state_s;

    urm_state_s st;
    urm_state_s next_st;
    urm_pkg::urm_char_s rxChar;
    logic rxIn;
    logic isRs485;
    logic wrEn;
    logic rdEn;
    logic storeChar;
    logic ninth;
    logic mapped;

    assign rxIn = st.rxSync[1];
    assign isRs485 = (st.funcSel[1:0] == urm_pkg::FUNC_RS485);
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = st.rdata;
    assign txPin = st.txOut;
    assign rtsPin = st.rtsOut;
    assign addrIrq = st.addrFlag && st.ien[urm_pkg::ISR_ADDR_IF - 16];

    always_comb begin
        unique case (paddr)
            urm_pkg::OFF_DATA, urm_pkg::OFF_IEN, urm_pkg::OFF_FIFO_CTL,
            urm_pkg::OFF_LINE_CTL, urm_pkg::OFF_MODEM_CTL, urm_pkg::OFF_MODEM_STS,
            urm_pkg::OFF_FIFO_STS, urm_pkg::OFF_INT_STS, urm_pkg::OFF_TIMEOUT,
            urm_pkg::OFF_BAUD, urm_pkg::OFF_IRDA, urm_pkg::OFF_ALT_CTL,
            urm_pkg::OFF_FUNC_SEL: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // parity slot: stick gives constant, else computed parity
    always_comb begin
        if (st.lineCtl[urm_pkg::LCR_STICK]) begin
            ninth = !st.lineCtl[urm_pkg::LCR_EVEN];
        end else begin
            ninth = (^st.thr) ^ !st.lineCtl[urm_pkg::LCR_EVEN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive filter: which completed characters reach the buffer
    always_comb begin
        storeChar = 1'b1;
        if (isRs485 && st.altCtl[urm_pkg::ALT_AUTO_ADDR]) begin
            if (rxChar.data[8]) begin
                storeChar = (rxChar.data[7:0] == st.altCtl[urm_pkg::ALT_ADDR_LSB +: 8]);
            end else begin
                storeChar = st.addrMatched;
            end
        end else if (isRs485 && st.altCtl[urm_pkg::ALT_MULTIDROP]) begin
            storeChar = rxChar.data[8] || !st.fifoCtl[urm_pkg::FCR_RX_OFF];
        end
    end

    always_comb begin
        next_st = st;
        rxChar = '0;
        next_st.rxSync = {st.rxSync[0], rxPin};

        // apb registers
        // read data loads in the setup cycle so it already stands at the access edge
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                urm_pkg::OFF_DATA: next_st.rdata = {24'h00_0000, st.rxBuf};
                urm_pkg::OFF_IEN: next_st.rdata = st.ien;
                urm_pkg::OFF_FIFO_CTL: next_st.rdata = st.fifoCtl;
                urm_pkg::OFF_LINE_CTL: next_st.rdata = st.lineCtl;
                urm_pkg::OFF_MODEM_CTL: next_st.rdata = {st.modemCtl[31:14], st.rtsOut,
                    st.modemCtl[12:0]};
                urm_pkg::OFF_MODEM_STS: next_st.rdata = urm_pkg::RST_MODEM_STS;
                urm_pkg::OFF_FIFO_STS: next_st.rdata = {urm_pkg::RST_FIFO_STS[31:1],
                    st.rxFull};
                urm_pkg::OFF_INT_STS: next_st.rdata = {15'h0000, st.addrFlag,
                    urm_pkg::RST_INT_STS[15:0]};
                urm_pkg::OFF_TIMEOUT: next_st.rdata = st.timeout;
                urm_pkg::OFF_BAUD: next_st.rdata = st.baud;
                urm_pkg::OFF_IRDA: next_st.rdata = st.irda;
                urm_pkg::OFF_ALT_CTL: next_st.rdata = st.altCtl;
                urm_pkg::OFF_FUNC_SEL: next_st.rdata = st.funcSel;
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
        if (rdEn && paddr == urm_pkg::OFF_DATA) begin
            next_st.rxFull = 1'b0;
        end
        if (wrEn && mapped) begin
            unique case (paddr)
                urm_pkg::OFF_DATA: begin
                    next_st.thr = pwdata[7:0];
                    next_st.thrFull = 1'b1;
                end
                urm_pkg::OFF_IEN: next_st.ien = pwdata;
                urm_pkg::OFF_FIFO_CTL: next_st.fifoCtl = pwdata;
                urm_pkg::OFF_LINE_CTL: next_st.lineCtl = pwdata;
                urm_pkg::OFF_MODEM_CTL: next_st.modemCtl = pwdata;
                urm_pkg::OFF_INT_STS: begin
                    if (pwdata[urm_pkg::ISR_ADDR_IF]) begin
                        next_st.addrFlag = 1'b0;
                    end
                end
                urm_pkg::OFF_TIMEOUT: next_st.timeout = pwdata;
                urm_pkg::OFF_BAUD: next_st.baud = pwdata;
                urm_pkg::OFF_IRDA: next_st.irda = pwdata;
                urm_pkg::OFF_ALT_CTL: next_st.altCtl = pwdata;
                urm_pkg::OFF_FUNC_SEL: next_st.funcSel = pwdata;
                default: next_st.funcSel = st.funcSel;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // transmitter: start, 8 data LSB first, ninth, stop
        unique case (st.txState)
            urm_pkg::TX_IDLE: begin
                next_st.txOut = 1'b1;
                if (st.thrFull) begin
                    next_st.txShift = {1'b1, ninth, st.thr};
                    next_st.thrFull = 1'b0;
                    next_st.txOut = 1'b0;
                    next_st.txIdx = 4'h0;
                    next_st.txBitCnt = 8'h00;
                    next_st.driveEn = 1'b1;
                    next_st.txState = urm_pkg::TX_SHIFT;
                end
            end
            urm_pkg::TX_SHIFT: begin
                next_st.txBitCnt = st.txBitCnt + 8'h01;
                if (st.txBitCnt == urm_pkg::BIT_CNT_MAX) begin
                    next_st.txBitCnt = 8'h00;
                    next_st.txOut = st.txShift[0];
                    next_st.txShift = {1'b1, st.txShift[9:1]};
                    next_st.txIdx = st.txIdx + 4'h1;
                    if (st.txIdx == 4'h9) begin
                        next_st.txState = urm_pkg::TX_HOLD;
                    end
                end
            end
            urm_pkg::TX_HOLD: begin
                // stop bit on the line for one bit time
                next_st.txBitCnt = st.txBitCnt + 8'h01;
                if (st.txBitCnt == urm_pkg::BIT_CNT_MAX) begin
                    next_st.txBitCnt = 8'h00;
                    next_st.txTurn = st.timeout[urm_pkg::TOR_TURN_LSB +: 8];
                    next_st.txState = urm_pkg::TX_DELAY;
                end
            end
            urm_pkg::TX_DELAY: begin
                // back-to-back characters keep the driver on
                if (st.thrFull) begin
                    next_st.txState = urm_pkg::TX_IDLE;
                end else if (st.txTurn == 8'h00) begin
                    next_st.driveEn = 1'b0;
                    next_st.txState = urm_pkg::TX_IDLE;
                end else begin
                    next_st.txBitCnt = st.txBitCnt + 8'h01;
                    if (st.txBitCnt == urm_pkg::BIT_CNT_MAX) begin
                        next_st.txBitCnt = 8'h00;
                        next_st.txTurn = st.txTurn - 8'h01;
                    end
                end
            end
            default: next_st.txState = urm_pkg::TX_IDLE;
        endcase
        if (st.lineCtl[urm_pkg::LCR_BREAK]) begin
            next_st.txOut = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////
        // receiver, sampled mid-bit
        unique case (st.rxState)
            urm_pkg::RX_IDLE: begin
                if (!rxIn) begin
                    next_st.rxBitCnt = 8'(urm_pkg::BIT_CYCLES / 2);
                    next_st.rxIdx = 4'h0;
                    next_st.rxState = urm_pkg::RX_SHIFT;
                end
            end
            urm_pkg::RX_SHIFT: begin
                next_st.rxBitCnt = st.rxBitCnt + 8'h01;
                if (st.rxBitCnt == urm_pkg::BIT_CNT_MAX) begin
                    next_st.rxBitCnt = 8'h00;
                    next_st.rxIdx = st.rxIdx + 4'h1;
                    if (st.rxIdx == 4'h0 && rxIn) begin
                        next_st.rxState = urm_pkg::RX_IDLE; // false start
                    end else if (st.rxIdx == 4'ha) begin
                        rxChar.data = st.rxShift;
                        rxChar.valid = 1'b1;
                        next_st.rxState = urm_pkg::RX_IDLE;
                    end else if (st.rxIdx != 4'h0) begin
                        next_st.rxShift = {rxIn, st.rxShift[8:1]};
                    end
                end
            end
            default: next_st.rxState = urm_pkg::RX_IDLE;
        endcase

        if (rxChar.valid) begin
            if (isRs485 && st.altCtl[urm_pkg::ALT_AUTO_ADDR] && rxChar.data[8]) begin
                next_st.addrMatched = storeChar;
            end
            if (isRs485 && st.altCtl[urm_pkg::ALT_MULTIDROP] && rxChar.data[8]) begin
                next_st.addrFlag = 1'b1;
                next_st.fifoCtl[urm_pkg::FCR_RX_OFF] = 1'b0;
            end
            if (storeChar) begin
                next_st.rxBuf = rxChar.data[7:0];
                next_st.rxFull = 1'b1;
            end
        end

        // driver enable or software rts, level-adjusted
        if (isRs485 && st.altCtl[urm_pkg::ALT_AUTO_DIR]) begin
            next_st.rtsOut = st.driveEn ~^ st.modemCtl[urm_pkg::MCR_LEV_RTS];
        end else begin
            next_st.rtsOut = st.modemCtl[urm_pkg::MCR_RTS] ~^ st.modemCtl[urm_pkg::MCR_LEV_RTS];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.fifoCtl <= urm_pkg::RST_FIFO_CTL;
            st.modemCtl <= urm_pkg::RST_MODEM_CTL;
            st.baud <= urm_pkg::RST_BAUD;
            st.irda <= urm_pkg::RST_IRDA;
            st.rxSync <= 2'b11;
            st.txState <= urm_pkg::TX_IDLE;
            st.rxState <= urm_pkg::RX_IDLE;
            st.txOut <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_rts_dir;
        @(posedge ref_clk) disable iff (!nrst)
        (isRs485 && st.altCtl[urm_pkg::ALT_AUTO_DIR]) |=>
            (rtsPin == ($past(st.driveEn) ~^ $past(st.modemCtl[urm_pkg::MCR_LEV_RTS])));
    endproperty
    a_rts_dir: assert property (p_rts_dir) else $error("rts not following driver enable");

    property p_rx_off_clear;
        @(posedge ref_clk) disable iff (!nrst)
        (rxChar.valid && isRs485 && st.altCtl[urm_pkg::ALT_MULTIDROP] && rxChar.data[8]) |=>
            (!st.fifoCtl[urm_pkg::FCR_RX_OFF] && st.rxFull && st.addrFlag);
    endproperty
    a_rx_off_clear: assert property (p_rx_off_clear) else $error("address not handled");

    property p_multidrop_drop;
        @(posedge ref_clk) disable iff (!nrst)
        (rxChar.valid && isRs485 && !st.altCtl[urm_pkg::ALT_AUTO_ADDR]
            && st.altCtl[urm_pkg::ALT_MULTIDROP] && st.fifoCtl[urm_pkg::FCR_RX_OFF]
            && !rxChar.data[8] && !rdEn && !st.rxFull)
            |=> !st.rxFull;
    endproperty
    a_multidrop_drop: assert property (p_multidrop_drop) else $error("data stored while off");

    property p_addr_match;
        @(posedge ref_clk) disable iff (!nrst)
        (rxChar.valid && isRs485 && st.altCtl[urm_pkg::ALT_AUTO_ADDR] && rxChar.data[8]) |=>
            (st.addrMatched == ($past(rxChar.data[7:0]) == $past(st.altCtl[31:24])));
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("match state wrong");

    property p_stick;
        @(posedge ref_clk) disable iff (!nrst)
        (st.txState == urm_pkg::TX_IDLE && st.thrFull && st.lineCtl[urm_pkg::LCR_STICK]) |=>
            (st.txShift[8] == !$past(st.lineCtl[urm_pkg::LCR_EVEN]));
    endproperty
    a_stick: assert property (p_stick) else $error("stick ninth bit wrong");

    property p_start_bit;
        @(posedge ref_clk) disable iff (!nrst)
        (st.txState == urm_pkg::TX_IDLE && st.thrFull && !st.lineCtl[urm_pkg::LCR_BREAK]) |=>
            (!txPin && st.driveEn)[*8];
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("start bit wrong");

    property p_delay_hold;
        @(posedge ref_clk) disable iff (!nrst)
        (st.txState == urm_pkg::TX_DELAY && st.txTurn != 8'h00) |=> st.driveEn;
    endproperty
    a_delay_hold: assert property (p_delay_hold) else $error("driver released early");

    property p_plain_store;
        @(posedge ref_clk) disable iff (!nrst)
        (rxChar.valid && !isRs485) |=> (st.rxFull && st.rxBuf == $past(rxChar.data[7:0]));
    endproperty
    a_plain_store: assert property (p_plain_store) else $error("plain char lost");

    c_auto_addr: cover property (@(posedge ref_clk)
        rxChar.valid && st.altCtl[urm_pkg::ALT_AUTO_ADDR]);
    c_multidrop_addr: cover property (@(posedge ref_clk)
        rxChar.valid && rxChar.data[8] && st.altCtl[urm_pkg::ALT_MULTIDROP]);
    c_release: cover property (@(posedge ref_clk) $fell(st.driveEn));

endmodule

// >>> urm_station.sv
/*
 * Remote RS-485 station model: sends 11-bit frames on the port's receive
 * line and decodes frames from its transmit line.
 * Assumes the fixed bit time of the package and a biased idle-high bus.
 */
`timescale 1ns/1ps
module urm_station (
    input wire logic ref_clk, // system clock
    input wire logic txPin, // line from the port
    output logic rxPin // line into the port
);
    localparam int BT = urm_pkg::BIT_CYCLES;

    // fail-safe bias keeps the bus at mark between frames
    initial begin
        rxPin = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic send(input logic [8:0] c);
        int i;
        @(posedge ref_clk);
        rxPin <= 1'b0;
        repeat (BT) @(posedge ref_clk);
        for (i = 0; i < 9; i++) begin
            rxPin <= c[i];
            repeat (BT) @(posedge ref_clk);
        end
        rxPin <= 1'b1;
        repeat (BT) @(posedge ref_clk);
    endtask

    // samples mid-bit; bit 9 of the result is the stop bit
    task automatic recv(output logic [9:0] c);
        int i;
        @(negedge txPin);
        repeat (BT / 2) @(posedge ref_clk);
        for (i = 0; i < 10; i++) begin
            repeat (BT) @(posedge ref_clk);
            c[i] = txPin;
        end
    endtask
endmodule

// >>> tb_urm_uart.sv
/*
 * Self-checking bench of the RS-485 serial port: register map, receive
 * filtering in both multidrop modes, ninth bit and driver enable timing.
 * Assumes the station model and the zero-wait APB slave of the design.
 */
`timescale 1ns/1ps
module tb_urm_uart;
    logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic txPin, rtsPin, addrIrq, rxPin;
    logic [7:0] paddr, b;
    logic [31:0] pwdata, prdata, q;
    logic [9:0] fr;
    int err_count = 0;
    int n_checks = 0;
    int i, k, n, e;
    localparam logic [31:0] RV [13] = '{32'h0, 32'h0000_0101, 32'h0, 32'h0000_0200,
        32'h0000_0001, 32'h1040_4000, 32'h0000_000a, 32'h0, 32'h0f00_0000,
        32'h0000_0040, 32'h0, 32'h0, 32'h0};

    urm_uart i_urm_uart (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxPin(rxPin), .txPin(txPin), .rtsPin(rtsPin), .addrIrq(addrIrq));
    urm_station i_urm_station (.ref_clk(ref_clk), .txPin(txPin), .rxPin(rxPin));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // read data taken at the ready edge; trailing wait lets registered outputs settle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic rx_case(input logic [8:0] c, input logic keep);
        i_urm_station.send(c);
        repeat (20) @(posedge ref_clk);
        apb(1'b0, urm_pkg::OFF_FIFO_STS, 32'h0);
        chk({31'h0, q[0]}, {31'h0, keep});
        if (keep) begin
            apb(1'b0, urm_pkg::OFF_DATA, 32'h0);
            chk({24'h0, q[7:0]}, {24'h0, c[7:0]});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (80000) @(posedge ref_clk);
        err_count++;
        final_report();
    end

    initial begin
        void'($urandom(14052));
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        for (i = 0; i < 13; i++) begin
            apb(1'b0, (i < 12) ? 8'(4 * i + 4) : 8'h40, 32'h0);
            chk(q, RV[i]);
        end
        rx_case({1'b1, 8'($urandom)}, 1'b1);
        // auto direction set but port still plain serial
        apb(1'b1, urm_pkg::OFF_ALT_CTL, 32'h0000_0400);
        apb(1'b1, urm_pkg::OFF_MODEM_CTL, 32'h0000_0202);
        chk({31'h0, rtsPin}, 32'h1);
        apb(1'b1, urm_pkg::OFF_FUNC_SEL, 32'h0000_0003);
        chk({31'h0, rtsPin}, 32'h0);
        for (k = 0; k < 2; k++) begin
            b = 8'($urandom);
            e = (11 + 3 * k) * urm_pkg::BIT_CYCLES;
            apb(1'b1, urm_pkg::OFF_TIMEOUT, 32'(3 * k) << 8);
            apb(1'b1, urm_pkg::OFF_LINE_CTL, (k == 0) ? 32'h0000_0038 : 32'h0000_0028);
            fork
                apb(1'b1, urm_pkg::OFF_DATA, {24'h0, b});
                i_urm_station.recv(fr);
                begin
                    n = 0;
                    while (rtsPin !== 1'b1 && n < 50) begin
                        @(posedge ref_clk);
                        n++;
                    end
                    n = 0;
                    while (rtsPin === 1'b1 && n < 3000) begin
                        @(posedge ref_clk);
                        n++;
                    end
                end
            join
            chk({22'h0, fr}, {22'h0, 1'b1, k[0], b});
            chk({31'h0, n >= e - 3 && n <= e + 3}, 32'h1);
        end
        apb(1'b1, urm_pkg::OFF_MODEM_CTL, 32'h0000_0000);
        chk({31'h0, rtsPin}, 32'h1);
        apb(1'b1, urm_pkg::OFF_LINE_CTL, 32'h0000_0040);
        chk({31'h0, txPin}, 32'h0);
        apb(1'b1, urm_pkg::OFF_LINE_CTL, 32'h0000_0000);
        // normal multidrop, receiver gated until an address
        apb(1'b1, urm_pkg::OFF_IEN, 32'h0000_0001);
        apb(1'b1, urm_pkg::OFF_FIFO_CTL, 32'h0000_0100);
        apb(1'b1, urm_pkg::OFF_ALT_CTL, 32'h0000_0100);
        rx_case({1'b0, 8'($urandom)}, 1'b0);
        rx_case({1'b1, 8'($urandom)}, 1'b1);
        chk({31'h0, addrIrq}, 32'h1);
        apb(1'b0, urm_pkg::OFF_FIFO_CTL, 32'h0);
        chk({31'h0, q[8]}, 32'h0);
        apb(1'b0, urm_pkg::OFF_INT_STS, 32'h0);
        chk({31'h0, q[16]}, 32'h1);
        apb(1'b1, urm_pkg::OFF_INT_STS, 32'h0001_0000);
        chk({31'h0, addrIrq}, 32'h0);
        rx_case({1'b0, 8'($urandom)}, 1'b1);
        // auto address, match value differs from the first address in bit 7
        apb(1'b1, urm_pkg::OFF_ALT_CTL, 32'h5a00_0200);
        rx_case(9'h1da, 1'b0);
        rx_case({1'b0, 8'($urandom)}, 1'b0);
        rx_case(9'h15a, 1'b1);
        rx_case({1'b0, 8'($urandom)}, 1'b1);
        i_urm_station.send(9'h15b);
        apb(1'b0, urm_pkg::OFF_DATA, 32'h0);
        rx_case({1'b0, 8'($urandom)}, 1'b0);
        final_report();
    end
endmodule
